/* canopen_nmt_sdo_slave_tb.sv */
`timescale 1ns/1ns
// self-checking bench for the node protocol logic
module canopen_nmt_sdo_slave_tb;
    localparam logic [6:0] NODE = 7'h05;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] boot = 2'h0;
    logic ctrl_wr = 1'b0;
    logic [7:0] ctrl_val = 8'h00;
    logic sync_wr = 1'b0;
    logic [10:0] sync_val = 11'h000;
    logic emcy_req = 1'b0;
    logic hb_tick = 1'b0;
    logic [63:0] emcy_data = 64'h1122334455667788;
    logic od_ack = 1'b0;
    logic od_err = 1'b0;
    logic [31:0] od_abort = 32'h06020000;
    logic [31:0] od_rdata = 32'hd4c3b2a1;
    logic [2:0] od_rlen = 3'h0;
    logic rx_valid, tx_valid, tx_ready, pdo_en, pdo_rx, sync_rx, node_rst, comm_rst;
    logic od_req, od_write;
    logic [7:0] state, od_sub;
    logic [15:0] od_index;
    logic [31:0] od_wdata;
    logic [2:0] od_len;
    logic [10:0] sync_id;
    cnsl_pkg::cnsl_frame_t rx_frame, tx_frame, pdo_frame;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_tx = 0;
    int od_reqs = 0;

    cnsl_node dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .node_id_i(NODE),
        .boot_target_state_setting_i(boot), .network_state_control_write_i(ctrl_wr),
        .network_state_control_value_i(ctrl_val), .sync_id_write_i(sync_wr),
        .sync_id_i(sync_val), .rx_valid_i(rx_valid), .rx_frame_i(rx_frame),
        .tx_ready_i(tx_ready), .emcy_req_i(emcy_req), .emcy_data_i(emcy_data),
        .heartbeat_tick_i(hb_tick), .od_ack_i(od_ack), .od_err_i(od_err),
        .od_abort_i(od_abort), .od_rdata_i(od_rdata), .od_rlen_i(od_rlen),
        .tx_valid_o(tx_valid), .tx_frame_o(tx_frame), .network_state_o(state),
        .pdo_enable_o(pdo_en), .pdo_rx_valid_o(pdo_rx), .pdo_rx_frame_o(pdo_frame),
        .sync_rx_o(sync_rx), .sync_id_o(sync_id), .node_reset_o(node_rst),
        .comm_reset_o(comm_rst), .od_req_o(od_req), .od_write_o(od_write),
        .od_index_o(od_index), .od_sub_o(od_sub), .od_wdata_o(od_wdata), .od_len_o(od_len));
    cnsl_master_model m (.clock_i(clock_i), .tx_valid_i(tx_valid), .tx_frame_i(tx_frame),
        .rx_valid_o(rx_valid), .rx_frame_o(rx_frame), .tx_ready_o(tx_ready));

    always #25 clock_i = ~clock_i;
    // request counter and hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (od_req === 1'b1) od_reqs++;
        if (cycles == 4000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // waits for the next frame on the link and compares it
    task automatic expect_tx(input logic [10:0] id, input logic [3:0] dlc,
            input logic [63:0] data, input logic [63:0] mask);
        int k;
        k = 0;
        n_tx++;
        while (m.seen < n_tx && k < 40) begin
            tick(1);
            k++;
        end
        chk(64'(m.seen), 64'(n_tx), "tx count");
        chk(64'({m.last_frame.id, m.last_frame.dlc}), 64'({id, dlc}), "tx header");
        chk(m.last_frame.data & mask, data & mask, "tx data");
    endtask
    task automatic ctrl(input logic [7:0] v);
        @(negedge clock_i);
        ctrl_val = v;
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wr = 1'b0;
    endtask
    task automatic t_boot();
        tick(1);
        chk(64'(state), 64'h7f, "boot state");
        expect_tx(11'h700 + 11'(NODE), 4'h1, 64'h0, '1);
    endtask
    task automatic t_nmt();
        logic [23:0] tbl [8] = '{24'h010505, 24'h020504, 24'h80057f, 24'h020004,
            24'h80007f, 24'h01067f, 24'h010005, 24'h80057f};
        foreach (tbl[i]) begin
            m.nmt(tbl[i][23:16], tbl[i][15:8]);
            tick(1);
            chk(64'(state), 64'(tbl[i][7:0]), "nmt state");
            chk(64'(pdo_en), 64'(tbl[i][7:0] == 8'h05), "pdo enable");
        end
        m.send(11'h000, 4'h3, 64'h0501);
        tick(1);
        chk(64'(state), 64'h7f, "bad length");
        chk(64'(m.seen), 64'(n_tx), "no reply");
    endtask
    // one expedited transfer with the object side answering at once
    task automatic sdo_do(input logic [7:0] cs, input logic [31:0] wd, input logic er,
            input logic [2:0] len, input logic [7:0] rcs, input logic [31:0] rd);
        m.sdo(NODE, cs, 16'h2010, 8'h03, wd);
        chk(64'(od_req), 64'h1, "od request");
        chk(64'({od_write, od_index, od_sub}), 64'({cs != 8'h40, 16'h2010, 8'h03}), "addr");
        chk(64'(od_len), 64'(cs == 8'h40 ? 3'h0 : len), "len");
        if (cs != 8'h40) chk(64'(od_wdata), 64'(wd), "wdata");
        od_ack = 1'b1;
        od_err = er;
        od_rlen = len;
        tick(1);
        od_ack = 1'b0;
        od_err = 1'b0;
        expect_tx(11'h580 + 11'(NODE), 4'h8, {rd, 8'h03, 16'h2010, rcs},
            rcs == 8'h60 ? 64'hffffffff : '1);
    endtask
    task automatic t_sdo();
        logic [31:0] msk;
        for (int n = 1; n <= 4; n++) begin
            msk = 32'hffffffff >> (32 - 8 * n);
            sdo_do(8'h40, 32'h0, 1'b0, 3'(n), 8'h53 - 8'(4 * n), od_rdata & msk);
            sdo_do(8'h33 - 8'(4 * n), od_rdata & msk, 1'b0, 3'(n), 8'h60, 32'h0);
        end
        sdo_do(8'h40, 32'h0, 1'b1, 3'h4, 8'h80, od_abort);
        m.sdo(NODE, 8'h21, 16'h2010, 8'h03, 32'h0);
        expect_tx(11'h580 + 11'(NODE), 4'h8, 64'h05040001_03_2010_80, '1);
    endtask
    task automatic pdo_try(input logic pass);
        m.send(11'h201, 4'h8, 64'h0123456789abcdef);
        chk(64'(pdo_rx), 64'(pass), "pdo rx");
        if (pass) chk(pdo_frame.data, 64'h0123456789abcdef, "pdo data");
    endtask
    task automatic t_modes();
        int r0;
        ctrl(8'h05);
        chk(64'(state), 64'h05, "ctrl oper");
        pdo_try(1'b1);
        sdo_do(8'h2b, 32'h0000beef, 1'b0, 3'h2, 8'h60, 32'h0);
        ctrl(8'h04);
        chk(64'(state), 64'h04, "ctrl stop");
        r0 = od_reqs;
        m.sdo(NODE, 8'h40, 16'h2010, 8'h03, 32'h0);
        pdo_try(1'b0);
        tick(4);
        chk(64'(od_reqs - r0 + m.seen - n_tx), 64'h0, "stopped sdo");
        ctrl(8'h7f);
        chk(64'(state), 64'h7f, "ctrl preop");
        pdo_try(1'b0);
    endtask
    task automatic t_prio();
        m.ready_wait = 4;
        @(negedge clock_i);
        emcy_req = 1'b1;
        hb_tick = 1'b1;
        tick(1);
        emcy_req = 1'b0;
        hb_tick = 1'b0;
        expect_tx(11'h080 + 11'(NODE), 4'h8, emcy_data, '1);
        expect_tx(11'h700 + 11'(NODE), 4'h1, 64'h7f, 64'hff);
        m.ready_wait = 0;
    endtask
    // one reset action, then the state reached from the boot target
    task automatic rst_chk(input logic [1:0] pulses, input logic [7:0] after);
        chk(64'({state, node_rst, comm_rst}), 64'({8'h00, pulses}), "reset");
        tick(1);
        chk(64'({state, sync_id}), 64'({after, 11'h080}), "reboot");
        expect_tx(11'h700 + 11'(NODE), 4'h1, 64'h0, 64'hff);
    endtask
    task automatic t_reset();
        @(negedge clock_i);
        sync_val = 11'h123;
        sync_wr = 1'b1;
        tick(1);
        sync_wr = 1'b0;
        chk(64'(sync_id), 64'h123, "sync id");
        m.send(11'h123, 4'h0, 64'h0);
        chk(64'(sync_rx), 64'h1, "sync rx");
        m.nmt(8'h81, 8'(NODE));
        rst_chk(2'b10, 8'h7f);
        boot = 2'h1;
        m.nmt(8'h82, 8'h00);
        rst_chk(2'b01, 8'h04);
        boot = 2'h2;
        ctrl(8'h80);
        rst_chk(2'b10, 8'h05);
        boot = 2'h0;
        ctrl(8'h81);
        rst_chk(2'b01, 8'h7f);
    endtask
    initial begin
        tick(6);
        rst_n_i = 1'b1;
        t_boot();
        t_nmt();
        t_sdo();
        t_modes();
        t_prio();
        t_reset();
        end_of_test();
    end
endmodule

/* cnsl_id_pick.sv */
`timescale 1ns/1ns
// picks the lower of two pending identifiers
module cnsl_id_pick (
    input wire logic a_valid_i,
    input wire logic [10:0] a_id_i,
    input wire logic b_valid_i,
    input wire logic [10:0] b_id_i,
    output logic valid_o,
    output logic [10:0] id_o,
    output logic sel_b_o
);
    // lower identifier wins, a wins a tie
    assign sel_b_o = b_valid_i && (!a_valid_i || (b_id_i < a_id_i));
    assign valid_o = a_valid_i || b_valid_i;
    assign id_o = sel_b_o ? b_id_i : a_id_i;
endmodule

/* cnsl_master_model.sv */
`timescale 1ns/1ns
// nmt master and sdo client standing on the far side of the link
module cnsl_master_model (
    input wire logic clock_i,
    input wire logic tx_valid_i,
    input wire cnsl_pkg::cnsl_frame_t tx_frame_i,
    output logic rx_valid_o,
    output cnsl_pkg::cnsl_frame_t rx_frame_o,
    output logic tx_ready_o
);
    int ready_wait = 0;
    int seen = 0;
    int stall = 0;
    cnsl_pkg::cnsl_frame_t last_frame = '0;
    initial begin
        rx_valid_o = 1'b0;
        rx_frame_o = '0;
        tx_ready_o = 1'b0;
    end
    // one frame for one cycle; afterwards the bus shows the inverse pattern
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
        @(negedge clock_i);
        rx_frame_o = {id, dlc, data};
        rx_valid_o = 1'b1;
        @(negedge clock_i);
        rx_valid_o = 1'b0;
        rx_frame_o = ~rx_frame_o;
    endtask
    // management frame: identifier zero, two bytes, command then node
    task automatic nmt(input logic [7:0] cs, input logic [7:0] node);
        send(11'h000, 4'h2, {48'h0, node, cs});
    endtask
    // sdo request: command, index little endian, subindex, data
    task automatic sdo(input logic [6:0] node, input logic [7:0] cs, input logic [15:0] idx,
            input logic [7:0] sub, input logic [31:0] data);
        send(11'h600 + 11'(node), 4'h8, {data, sub, idx, cs});
    endtask
    // takes a frame when valid and ready meet; ready comes after ready_wait stalls
    always @(posedge clock_i) begin
        if (tx_valid_i && tx_ready_o) begin
            last_frame <= tx_frame_i;
            seen <= seen + 1;
            stall <= 0;
        end else if (tx_valid_i) begin
            stall <= stall + 1;
        end
    end
    always @(negedge clock_i) begin
        tx_ready_o = tx_valid_i && stall >= ready_wait;
    end
endmodule

/* cnsl_node.sv */
`timescale 1ns/1ns
module cnsl_node (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [6:0] node_id_i,
    input wire logic [1:0] boot_target_state_setting_i,
    input wire logic network_state_control_write_i,
    input wire logic [7:0] network_state_control_value_i,
    input wire logic sync_id_write_i,
    input wire logic [10:0] sync_id_i,
    input wire logic rx_valid_i,
    input wire cnsl_pkg::cnsl_frame_t rx_frame_i,
    input wire logic tx_ready_i,
    input wire logic emcy_req_i,
    input wire logic [63:0] emcy_data_i,
    input wire logic heartbeat_tick_i,
    input wire logic od_ack_i,
    input wire logic od_err_i,
    input wire logic [31:0] od_abort_i,
    input wire logic [31:0] od_rdata_i,
    input wire logic [2:0] od_rlen_i,
    output logic tx_valid_o,
    output cnsl_pkg::cnsl_frame_t tx_frame_o,
    output logic [7:0] network_state_o,
    output logic pdo_enable_o,
    output logic pdo_rx_valid_o,
    output cnsl_pkg::cnsl_frame_t pdo_rx_frame_o,
    output logic sync_rx_o,
    output logic [10:0] sync_id_o,
    output logic node_reset_o,
    output logic comm_reset_o,
    output logic od_req_o,
    output logic od_write_o,
    output logic [15:0] od_index_o,
    output logic [7:0] od_sub_o,
    output logic [31:0] od_wdata_o,
    output logic [2:0] od_len_o
);
    cnsl_pkg::cnsl_state_t state_reg, state_next, boot_state;
    logic [10:0] sync_id_reg;
    logic tx_valid_reg, pdo_en_reg, pdo_valid_reg, sync_rx_reg;
    cnsl_pkg::cnsl_frame_t tx_frame_reg, pdo_frame_reg;
    logic node_rst_reg, comm_rst_reg;
    logic hb_pend_reg, emcy_pend_reg, sdo_pend_reg, sdo_busy_reg;
    logic [7:0] hb_code_reg;
    logic [63:0] emcy_data_reg, sdo_resp_reg;
    logic od_req_reg, od_write_reg;
    logic [15:0] od_index_reg;
    logic [7:0] od_sub_reg;
    logic [31:0] od_wdata_reg;
    logic [2:0] od_len_reg;

    // identifiers derived from the node number
    wire [10:0] node_ext = {4'h0, node_id_i};
    wire [10:0] emcy_id = cnsl_pkg::EMCY_BASE + node_ext;
    wire [10:0] sdo_rx_id = cnsl_pkg::SDO_RX_BASE + node_ext;
    wire [10:0] sdo_tx_id = cnsl_pkg::SDO_TX_BASE + node_ext;
    wire [10:0] hb_id = cnsl_pkg::GUARD_BASE + node_ext;

    // management frame decode
    wire [7:0] nmt_cs = rx_frame_i.data[7:0];
    wire [7:0] nmt_node = rx_frame_i.data[15:8];
    wire rx_nmt = rx_valid_i && rx_frame_i.id == cnsl_pkg::COB_NMT
        && rx_frame_i.dlc == cnsl_pkg::NMT_DLC;
    wire nmt_mine = rx_nmt && (nmt_node == {1'b0, node_id_i}
        || nmt_node == cnsl_pkg::NODE_ALL);
    wire live = state_reg != cnsl_pkg::CNSL_INIT;
    wire is_preop = state_reg == cnsl_pkg::CNSL_PREOP;
    wire is_oper = state_reg == cnsl_pkg::CNSL_OPER;
    wire is_stop = state_reg == cnsl_pkg::CNSL_STOPPED;
    wire sdo_open = is_preop || is_oper;

    // commands from the link, gated by source state
    wire n_start = nmt_mine && nmt_cs == cnsl_pkg::NMT_START && (is_preop || is_stop);
    wire n_stop = nmt_mine && nmt_cs == cnsl_pkg::NMT_STOP && (is_preop || is_oper);
    wire n_preop = nmt_mine && nmt_cs == cnsl_pkg::NMT_PREOP && (is_oper || is_stop);
    wire n_rnode = nmt_mine && nmt_cs == cnsl_pkg::NMT_RST_NODE;
    wire n_rcomm = nmt_mine && nmt_cs == cnsl_pkg::NMT_RST_COMM;
    // commands from the control value, forced from any live state
    wire cw = network_state_control_write_i && live;
    wire [7:0] cv = network_state_control_value_i;
    wire c_oper = cw && cv == cnsl_pkg::CNSL_OPER;
    wire c_stop = cw && cv == cnsl_pkg::CNSL_STOPPED;
    wire c_preop = cw && cv == cnsl_pkg::CNSL_PREOP;
    wire c_rnode = cw && cv == cnsl_pkg::CTRL_RST_NODE;
    wire c_rcomm = cw && cv == cnsl_pkg::CTRL_RST_COMM;
    wire do_rnode = live && (n_rnode || c_rnode);
    wire do_rcomm = live && !do_rnode && (n_rcomm || c_rcomm);
    wire any_rst = do_rnode || do_rcomm;

    // boot target selection
    assign boot_state = boot_target_state_setting_i == cnsl_pkg::CNSL_BOOT_STOP
        ? cnsl_pkg::CNSL_STOPPED
        : boot_target_state_setting_i == cnsl_pkg::CNSL_BOOT_OPER
        ? cnsl_pkg::CNSL_OPER : cnsl_pkg::CNSL_PREOP;

    // network state transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cnsl_pkg::CNSL_INIT: state_next = boot_state;
            cnsl_pkg::CNSL_PREOP, cnsl_pkg::CNSL_OPER, cnsl_pkg::CNSL_STOPPED: begin
                if (any_rst) begin
                    state_next = cnsl_pkg::CNSL_INIT;
                end else if (n_start || n_stop || n_preop) begin
                    state_next = n_start ? cnsl_pkg::CNSL_OPER
                        : n_stop ? cnsl_pkg::CNSL_STOPPED : cnsl_pkg::CNSL_PREOP;
                end else if (c_oper || c_stop || c_preop) begin
                    state_next = cnsl_pkg::cnsl_state_t'(cv);
                end
            end
            default: state_next = cnsl_pkg::CNSL_INIT;
        endcase
    end

    // sync and process data receive decode
    wire rx_sdo = rx_valid_i && rx_frame_i.id == sdo_rx_id
        && rx_frame_i.dlc == cnsl_pkg::SDO_DLC && sdo_open;
    wire rx_sync = rx_valid_i && rx_frame_i.id == sync_id_reg && sdo_open;
    wire rx_other = rx_valid_i && rx_frame_i.id != cnsl_pkg::COB_NMT
        && rx_frame_i.id != sdo_rx_id && rx_frame_i.id != sync_id_reg;
    wire rx_pdo = rx_other && is_oper;

    // sdo request decode
    wire [7:0] sdo_cs = rx_frame_i.data[7:0];
    wire [15:0] sdo_idx = rx_frame_i.data[23:8];
    wire [7:0] sdo_sub = rx_frame_i.data[31:24];
    wire sdo_free = !sdo_busy_reg && !sdo_pend_reg;
    wire sdo_rd = sdo_cs == cnsl_pkg::SDO_RD_REQ;
    // expedited writes are 23h, 27h, 2bh and 2fh: high nibble 2, low bits 11
    wire sdo_wr = sdo_cs[7:4] == cnsl_pkg::SDO_WR_TOP && sdo_cs[1:0] == 2'h3;
    wire sdo_take = rx_sdo && sdo_free;
    wire [2:0] wr_len = 3'h4 - {1'b0, sdo_cs[3:2]};
    wire [2:0] rlen_fix = (od_rlen_i == 3'h0 || od_rlen_i > 3'h4) ? 3'h4 : od_rlen_i;
    wire [2:0] rd_gap = 3'h4 - rlen_fix;
    wire [7:0] rd_cs = cnsl_pkg::SDO_RD_REPLY | {4'h0, rd_gap[1:0], 2'h0};
    wire [31:0] rd_mask = 32'hffffffff >> {rd_gap, 3'h0};
    wire [23:0] hdr_req = {sdo_sub, sdo_idx};
    wire [23:0] hdr_hold = {od_sub_reg, od_index_reg};
    wire od_done = od_ack_i && sdo_busy_reg;
    wire [63:0] resp_done = od_err_i ? {od_abort_i, hdr_hold, cnsl_pkg::SDO_ERR}
        : od_write_reg ? {32'h0, hdr_hold, cnsl_pkg::SDO_WR_ACK}
        : {od_rdata_i & rd_mask, hdr_hold, rd_cs};
    wire [63:0] resp_bad = {cnsl_pkg::ABORT_BAD_CS, hdr_req, cnsl_pkg::SDO_ERR};

    // transmit arbitration: lowest identifier first
    wire tx_free = !tx_valid_reg || tx_ready_i;
    wire emcy_req = emcy_pend_reg && sdo_open;
    wire sdo_req = sdo_pend_reg && sdo_open;
    wire ab_valid, ab_sel_sdo, win_sel_hb, win_valid;
    wire [10:0] ab_id, win_id;
    cnsl_id_pick pick_ab (
        .a_valid_i(emcy_req),
        .a_id_i(emcy_id),
        .b_valid_i(sdo_req),
        .b_id_i(sdo_tx_id),
        .valid_o(ab_valid),
        .id_o(ab_id),
        .sel_b_o(ab_sel_sdo)
    );
    cnsl_id_pick pick_win (
        .a_valid_i(ab_valid),
        .a_id_i(ab_id),
        .b_valid_i(hb_pend_reg),
        .b_id_i(hb_id),
        .valid_o(win_valid),
        .id_o(win_id),
        .sel_b_o(win_sel_hb)
    );
    wire tx_load = tx_free && win_valid;
    wire ld_hb = tx_load && win_sel_hb;
    wire ld_sdo = tx_load && !win_sel_hb && ab_sel_sdo;
    wire ld_emcy = tx_load && !win_sel_hb && !ab_sel_sdo;
    wire [3:0] win_dlc = win_sel_hb ? cnsl_pkg::HB_DLC
        : ab_sel_sdo ? cnsl_pkg::SDO_DLC : cnsl_pkg::EMCY_DLC;
    wire [63:0] win_data = win_sel_hb ? {56'h0, hb_code_reg}
        : ab_sel_sdo ? sdo_resp_reg : emcy_data_reg;
    wire hb_set = state_reg == cnsl_pkg::CNSL_INIT || heartbeat_tick_i;
    wire emcy_set = emcy_req_i && sdo_open;
    wire sdo_set = (sdo_take && !sdo_rd && !sdo_wr) || od_done;

    // network state and reset pulses
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= cnsl_pkg::CNSL_INIT;
            pdo_en_reg <= 1'b0;
            node_rst_reg <= 1'b0;
            comm_rst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pdo_en_reg <= state_next == cnsl_pkg::CNSL_OPER;
            node_rst_reg <= do_rnode;
            comm_rst_reg <= do_rcomm;
        end
    end

    // sync identifier, restored by either reset command
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync_id_reg <= cnsl_pkg::SYNC_ID_RST;
        end else if (any_rst) begin
            sync_id_reg <= cnsl_pkg::SYNC_ID_RST;
        end else if (sync_id_write_i) begin
            sync_id_reg <= sync_id_i;
        end
    end

    // receive side pulses to the application
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync_rx_reg <= 1'b0;
            pdo_valid_reg <= 1'b0;
            pdo_frame_reg <= '0;
        end else begin
            sync_rx_reg <= rx_sync;
            pdo_valid_reg <= rx_pdo;
            if (rx_pdo) begin
                pdo_frame_reg <= rx_frame_i;
            end
        end
    end

    // pending transmit requests, a set beats a clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hb_pend_reg <= 1'b0;
            hb_code_reg <= 8'h00;
            emcy_pend_reg <= 1'b0;
            emcy_data_reg <= 64'h0;
        end else begin
            hb_pend_reg <= hb_set || (hb_pend_reg && !ld_hb);
            if (hb_set) begin
                hb_code_reg <= state_reg; // boot-up sends zero
            end
            emcy_pend_reg <= emcy_set || (emcy_pend_reg && !ld_emcy && !any_rst);
            if (emcy_set) begin
                emcy_data_reg <= emcy_data_i;
            end
        end
    end

    // sdo server: one expedited transfer at a time
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sdo_busy_reg <= 1'b0;
            sdo_pend_reg <= 1'b0;
            sdo_resp_reg <= 64'h0;
        end else begin
            sdo_busy_reg <= (sdo_take && (sdo_rd || sdo_wr))
                || (sdo_busy_reg && !od_ack_i && !any_rst);
            sdo_pend_reg <= sdo_set
                || (sdo_pend_reg && !ld_sdo && sdo_open && !any_rst);
            if (od_done) begin
                sdo_resp_reg <= resp_done;
            end else if (sdo_take) begin
                sdo_resp_reg <= resp_bad;
            end
        end
    end

    // object access request toward the application
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            od_req_reg <= 1'b0;
            od_write_reg <= 1'b0;
            od_index_reg <= 16'h0;
            od_sub_reg <= 8'h00;
            od_wdata_reg <= 32'h0;
            od_len_reg <= 3'h0;
        end else begin
            od_req_reg <= sdo_take && (sdo_rd || sdo_wr);
            if (sdo_take && (sdo_rd || sdo_wr)) begin
                od_write_reg <= sdo_wr;
                od_index_reg <= sdo_idx;
                od_sub_reg <= sdo_sub;
                od_wdata_reg <= rx_frame_i.data[63:32];
                od_len_reg <= sdo_wr ? wr_len : 3'h0;
            end
        end
    end

    // transmit holding register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tx_valid_reg <= 1'b0;
            tx_frame_reg <= '0;
        end else begin
            if (tx_load) begin
                tx_frame_reg <= '{id: win_id, dlc: win_dlc, data: win_data};
            end
            tx_valid_reg <= tx_load || (tx_valid_reg && !tx_ready_i);
        end
    end

    assign tx_valid_o = tx_valid_reg;
    assign tx_frame_o = tx_frame_reg;
    assign network_state_o = state_reg;
    assign pdo_enable_o = pdo_en_reg;
    assign pdo_rx_valid_o = pdo_valid_reg;
    assign pdo_rx_frame_o = pdo_frame_reg;
    assign sync_rx_o = sync_rx_reg;
    assign sync_id_o = sync_id_reg;
    assign node_reset_o = node_rst_reg;
    assign comm_reset_o = comm_rst_reg;
    assign od_req_o = od_req_reg;
    assign od_write_o = od_write_reg;
    assign od_index_o = od_index_reg;
    assign od_sub_o = od_sub_reg;
    assign od_wdata_o = od_wdata_reg;
    assign od_len_o = od_len_reg;

    // checks
    chk_nmt_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        n_start && !any_rst |=> state_reg == cnsl_pkg::CNSL_OPER)
        else $error("start command did not reach operational");
    chk_foreign_nmt: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rx_nmt && !nmt_mine && !cw && live |=> $stable(state_reg))
        else $error("foreign management frame changed state");
    chk_stopped_sdo: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        is_stop |=> !od_req_o)
        else $error("object request issued while stopped");
    chk_pdo_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pdo_rx_valid_o |-> $past(state_reg) == cnsl_pkg::CNSL_OPER)
        else $error("process data passed outside operational");
    chk_boot_target: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_reg == cnsl_pkg::CNSL_INIT |=> state_reg == $past(boot_state))
        else $error("initialisation left to wrong state");
    chk_sync_reset: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        any_rst |=> sync_id_o == cnsl_pkg::SYNC_ID_RST)
        else $error("sync identifier not restored");
    chk_node_reset: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        do_rnode |=> node_reset_o && state_reg == cnsl_pkg::CNSL_INIT ##1 !node_reset_o)
        else $error("reset node pulse or state wrong");
    chk_tx_order: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tx_load && emcy_req |=> tx_frame_o.id == emcy_id)
        else $error("emergency not sent before higher identifiers");
    chk_sdo_reply: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        od_done && sdo_open && !any_rst |-> ##[1:4] tx_valid_o && tx_frame_o.id == sdo_tx_id)
        else $error("sdo transfer not confirmed");
endmodule

/* cnsl_pkg.sv */
// Functional notes
// - every object identifier is eleven bits
// - lowest pending identifier is served first
// - management frames: identifier zero, two bytes
// - sync identifier configurable, resets to 80h
// - emergency identifier is 80h plus node
// - sdo in at 600h, out at 580h
// - guarding and heartbeat at 700h plus node
// - boot into pre-operational unless target says otherwise
// - pre-operational: no process data, sdo served
// - operational: sdo and process data both
// - stopped: management only, no sdo
// - start, stop, pre-operational transitions as listed
// - reset node reinitialises all objects
// - reset communication reinitialises communication objects
// - byte0 command, byte1 node; five codes
// - act on own node number or zero
// - state value shown; writes force state/action
// - every transfer confirmed; expedited up to four (code drops a request arriving while one is in progress, unanswered)
// - sdo bytes: command, index, subindex, data
// - sdo command codes select access type
package cnsl_pkg;
    localparam int ID_W = 11;
    localparam logic [10:0] COB_NMT = 11'h000;
    localparam logic [10:0] SYNC_ID_RST = 11'h080;
    localparam logic [10:0] EMCY_BASE = 11'h080;
    localparam logic [10:0] SDO_RX_BASE = 11'h600;
    localparam logic [10:0] SDO_TX_BASE = 11'h580;
    localparam logic [10:0] GUARD_BASE = 11'h700;
    localparam logic [3:0] NMT_DLC = 4'h2;
    localparam logic [3:0] SDO_DLC = 4'h8;
    localparam logic [3:0] HB_DLC = 4'h1;
    localparam logic [3:0] EMCY_DLC = 4'h8;
    // management command specifiers
    localparam logic [7:0] NMT_START = 8'h01;
    localparam logic [7:0] NMT_STOP = 8'h02;
    localparam logic [7:0] NMT_PREOP = 8'h80;
    localparam logic [7:0] NMT_RST_NODE = 8'h81;
    localparam logic [7:0] NMT_RST_COMM = 8'h82;
    localparam logic [7:0] NODE_ALL = 8'h00;
    // control value actions
    localparam logic [7:0] CTRL_RST_NODE = 8'h80;
    localparam logic [7:0] CTRL_RST_COMM = 8'h81;
    // sdo command bytes
    localparam logic [7:0] SDO_RD_REQ = 8'h40;
    localparam logic [7:0] SDO_WR_ACK = 8'h60;
    localparam logic [7:0] SDO_ERR = 8'h80;
    localparam logic [7:0] SDO_RD_REPLY = 8'h43;
    localparam logic [3:0] SDO_WR_TOP = 4'h2;
    localparam logic [31:0] ABORT_BAD_CS = 32'h05040001;
    typedef enum logic [7:0] {
        CNSL_INIT = 8'h00,
        CNSL_STOPPED = 8'h04,
        CNSL_OPER = 8'h05,
        CNSL_PREOP = 8'h7f
    } cnsl_state_t;
    typedef enum logic [1:0] {
        CNSL_BOOT_PREOP = 2'h0,
        CNSL_BOOT_STOP = 2'h1,
        CNSL_BOOT_OPER = 2'h2
    } cnsl_boot_t;
    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cnsl_frame_t;
endpackage
